//--- logic/sfsr_top.sv
// spi status responder: event flags, status word and miso shifting
`timescale 1ns/10ps
`default_nettype none
module sfsr_top
  import sfsr_pkg::*;
#(
  parameter int FRAME_BITS = 16
) (
  input  wire logic                clock_in,
  input  wire logic                resetn_in,
  input  wire logic                ce_in,
  input  wire logic                sclk_in,
  input  wire logic                cs_n_in,
  input  wire logic                mosi_in,
  output logic                     miso_out,
  output logic                     miso_oe_n_out,
  input  wire logic [SRC_W-1:0]    int_event_in,
  input  wire logic [SRC_W-1:0]    wake_event_in,
  input  wire logic [SRC_W-1:0]    reset_event_in,
  output logic [STATUS_W-1:0]      status_word_out,
  output logic                     frame_done_out,
  output logic [CMD_W-1:0]         frame_cmd_out,
  output logic [ADDR_W-1:0]        frame_addr_out
);
  // the bit counter must reach a full frame, and a frame must carry exactly one status word
  if (FRAME_BITS != STATUS_W || FRAME_BITS >= (1 << CNT_W)) begin : g_frame_bits_bad
    $error("sfsr_top: FRAME_BITS must equal the status word width");
  end

  sfsr_pin_if pins ();

  sfsr_sync u_sync (
    .clock_in  (clock_in),
    .resetn_in (resetn_in),
    .ce_in     (ce_in),
    .sclk_in   (sclk_in),
    .cs_n_in   (cs_n_in),
    .mosi_in   (mosi_in),
    .pins      (pins)
  );

  sfsr_state_e            state_q;
  logic                   sclk_prev_q;
  logic                   cs_prev_q;
  logic [CNT_W-1:0]       bit_cnt_q;
  logic [STATUS_W-1:0]    rx_q;
  sfsr_word_t             tx_q;
  logic                   write_q;
  logic [SRC_W-1:0]       pend_q [KIND_N];
  logic [SRC_W-1:0]       clr_mask [KIND_N];
  logic [SRC_W-1:0]       evt [KIND_N];
  sfsr_word_t             status_d;
  logic                   sclk_rise;
  logic                   sclk_fall;
  logic                   cs_fall;
  logic                   cs_rise;
  logic [CMD_W-1:0]       cmd;
  logic [ADDR_W-1:0]      addr;
  logic                   cmd_is_read;

  // edges are found on the synchronised pins, so every reaction lags the pin by about three clocks
  assign sclk_rise = pins.sclk & ~sclk_prev_q;
  assign sclk_fall = ~pins.sclk & sclk_prev_q;
  assign cs_fall   = ~pins.cs_n & cs_prev_q;
  assign cs_rise   = pins.cs_n & ~cs_prev_q;
  // command and address sit at the top of the received frame
  assign cmd       = rx_q[CMD_MSB -: CMD_W];
  assign addr      = rx_q[ADDR_MSB -: ADDR_W];
  assign cmd_is_read = (cmd == CMD_READ_A) || (cmd == CMD_READ_B);
  assign evt[KIND_INT] = int_event_in;
  assign evt[KIND_WU]  = wake_event_in;
  assign evt[KIND_RST] = reset_event_in;

  // builds the response word from the pending flags
  function automatic sfsr_word_t build_status(input logic [SRC_W-1:0] p [KIND_N]);
    logic [SRC_W-1:0] any;
    any = p[KIND_INT] | p[KIND_WU] | p[KIND_RST];
    build_status = {
      |p[KIND_INT],
      |p[KIND_WU],
      |p[KIND_RST],
      any[SRC_CANBUS] | any[SRC_CANLOC],
      any[SRC_LIN_CHANNEL_TWO_SOURCE] | any[SRC_LIN_CHANNEL_ONE_SOURCE],
      any[SRC_IO1] | any[SRC_IO0],
      any[SRC_SAFE],
      any[SRC_VREG1] | any[SRC_VREG0],
      any[SRC_CANBUS], any[SRC_CANLOC],
      any[SRC_LIN_CHANNEL_TWO_SOURCE], any[SRC_LIN_CHANNEL_ONE_SOURCE],
      any[SRC_IO1], any[SRC_IO0],
      any[SRC_VREG1], any[SRC_VREG0]
    };
  endfunction : build_status

  always_comb begin
    status_d = build_status(pend_q);
  end

  // only a complete read frame addressed at a flag register clears that kind
  always_comb begin
    for (int k = 0; k < KIND_N; k++) begin
      clr_mask[k] = '0;
    end
    if (state_q == SFSR_DONE && cmd_is_read) begin
      if (addr == ADDR_INT_FLAGS) clr_mask[KIND_INT] = '1;
      if (addr == ADDR_WU_FLAGS)  clr_mask[KIND_WU]  = '1;
      if (addr == ADDR_RST_FLAGS) clr_mask[KIND_RST] = '1;
    end
  end

  // an event in the clearing cycle survives: set wins over clear
  // flags are kept per kind and source, so clearing one kind leaves the others pending
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      for (int k = 0; k < KIND_N; k++) begin
        pend_q[k] <= PEND_RST;
      end
    end else if (ce_in) begin
      for (int k = 0; k < KIND_N; k++) begin
        pend_q[k] <= (pend_q[k] & ~clr_mask[k]) | evt[k];
      end
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sclk_prev_q <= 1'b0;
      cs_prev_q   <= 1'b1;
    end else if (ce_in) begin
      sclk_prev_q <= pins.sclk;
      cs_prev_q   <= pins.cs_n;
    end
  end

  // frame sequencer; a frame shorter than FRAME_BITS is dropped without effect, a longer one saturates the count and is taken
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_q <= SFSR_IDLE;
    end else if (ce_in) begin
      case (state_q)
        SFSR_IDLE: begin
          if (cs_fall) state_q <= SFSR_SHIFT;
        end
        SFSR_SHIFT: begin
          if (cs_rise) begin
            state_q <= (bit_cnt_q == CNT_W'(FRAME_BITS)) ? SFSR_DONE : SFSR_IDLE;
          end
        end
        SFSR_DONE: begin
          state_q <= SFSR_IDLE;
        end
        default: begin
          state_q <= SFSR_IDLE;
        end
      endcase
    end
  end

  // mosi is taken on the falling sclk edge
  // the command code is known after two bits, which fixes the reply length early
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rx_q      <= '0;
      bit_cnt_q <= '0;
      write_q   <= 1'b0;
    end else if (ce_in) begin
      if (state_q == SFSR_IDLE && cs_fall) begin
        bit_cnt_q <= '0;
        write_q   <= 1'b0;
      end else if (state_q == SFSR_SHIFT && sclk_fall && !pins.cs_n) begin
        rx_q <= {rx_q[STATUS_W-2:0], pins.mosi};
        if (bit_cnt_q != CNT_W'(FRAME_BITS)) bit_cnt_q <= bit_cnt_q + CNT_W'(1);
        if (bit_cnt_q == CNT_W'(CMD_W - 1)) begin
          write_q <= ({rx_q[0], pins.mosi} == CMD_WRITE);
        end
      end
    end
  end

  // snapshot at frame start keeps the word stable while it shifts out
  // bit 15 stands from frame start; every sclk rise, the first included, moves on one bit
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      tx_q <= STATUS_RST;
    end else if (ce_in) begin
      if (state_q == SFSR_IDLE && cs_fall) begin
        tx_q <= status_d;
      end else if (state_q == SFSR_SHIFT && sclk_rise) begin
        tx_q <= {tx_q[STATUS_W-2:0], 1'b0};
      end
    end
  end

  // after the first byte a read frame sends zeros: only a write frame shifts out all 16 status bits
  // the line is released between frames, so a host sees no stale bit there
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      miso_out      <= 1'b0;
      miso_oe_n_out <= 1'b1;
    end else if (ce_in) begin
      miso_oe_n_out <= ~(state_q == SFSR_SHIFT && !pins.cs_n);
      miso_out      <= (state_q == SFSR_SHIFT) && tx_q[STATUS_W-1] &&
                       ((bit_cnt_q < CNT_W'(BYTE_BITS)) || write_q);
    end
  end

  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      status_word_out <= STATUS_RST;
      frame_done_out  <= 1'b0;
      frame_cmd_out   <= '0;
      frame_addr_out  <= '0;
    end else if (ce_in) begin
      status_word_out <= status_d;
      frame_done_out  <= (state_q == SFSR_DONE);
      if (state_q == SFSR_DONE) begin
        frame_cmd_out  <= cmd;
        frame_addr_out <= addr;
      end
    end
  end
endmodule : sfsr_top
`default_nettype wire

//--- logic/sfsr_pkg.sv
// constants and types for the fixed spi status response block
package sfsr_pkg;
  localparam int          CMD_W          = 2;
  localparam int          ADDR_W         = 5;
  localparam int          STATUS_W       = 16;
  localparam int          BYTE_BITS      = 8;
  localparam int          SRC_W          = 9;
  localparam int          KIND_N         = 3;
  localparam int          CNT_W          = 5;
  localparam logic [1:0]  CMD_READ_A     = 2'h0;
  localparam logic [1:0]  CMD_WRITE      = 2'h1;
  localparam logic [1:0]  CMD_READ_B     = 2'h3;
  // frame layout: command then register address, msb first
  localparam int          CMD_MSB        = 15;
  localparam int          ADDR_MSB       = 13;
  // flag-register addresses whose read clears the event flags
  localparam logic [4:0]  ADDR_INT_FLAGS = 5'h1C;
  localparam logic [4:0]  ADDR_WU_FLAGS  = 5'h1D;
  localparam logic [4:0]  ADDR_RST_FLAGS = 5'h1E;
  // event kinds
  localparam int          KIND_INT       = 0;
  localparam int          KIND_WU        = 1;
  localparam int          KIND_RST       = 2;
  // source positions inside an event vector
  localparam int          SRC_VREG0      = 0;
  localparam int          SRC_VREG1      = 1;
  localparam int          SRC_IO0        = 2;
  localparam int          SRC_IO1        = 3;
  localparam int          SRC_LIN_CHANNEL_ONE_SOURCE       = 4;
  localparam int          SRC_LIN_CHANNEL_TWO_SOURCE       = 5;
  localparam int          SRC_CANLOC     = 6;
  localparam int          SRC_CANBUS     = 7;
  localparam int          SRC_SAFE       = 8;
  localparam logic [15:0] STATUS_RST     = 16'h0000;
  localparam logic [8:0]  PEND_RST       = 9'h000;
  typedef enum logic [1:0] {
    SFSR_IDLE  = 2'b00,
    SFSR_SHIFT = 2'b01,
    SFSR_DONE  = 2'b11
  } sfsr_state_e;
  typedef logic [STATUS_W-1:0] sfsr_word_t;
endpackage : sfsr_pkg

//--- logic/sfsr_pin_if.sv
// synchronised spi pin levels passed from the synchroniser to the core
`timescale 1ns/10ps
`default_nettype none
interface sfsr_pin_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  modport producer (output sclk, output cs_n, output mosi);
  modport consumer (input sclk, input cs_n, input mosi);
endinterface : sfsr_pin_if
`default_nettype wire

//--- logic/sfsr_sync.sv
// two-flop synchronisers for the spi pins
`timescale 1ns/10ps
`default_nettype none
module sfsr_sync (
  input  wire logic      clock_in,
  input  wire logic      resetn_in,
  input  wire logic      ce_in,
  input  wire logic      sclk_in,
  input  wire logic      cs_n_in,
  input  wire logic      mosi_in,
  sfsr_pin_if.producer   pins
);
  logic [2:0] meta_q;
  logic [2:0] sync_q;

  // chip select idles high so a reset does not look like a frame start
  always_ff @(posedge clock_in or negedge resetn_in) begin
    if (!resetn_in) begin
      meta_q <= 3'h2;
      sync_q <= 3'h2;
    end else if (ce_in) begin
      meta_q <= {mosi_in, cs_n_in, sclk_in};
      sync_q <= meta_q;
    end
  end

  assign pins.sclk = sync_q[0];
  assign pins.cs_n = sync_q[1];
  assign pins.mosi = sync_q[2];
endmodule : sfsr_sync
`default_nettype wire

//--- verification/sfsr_top_sva.sv
// concurrent checks on the status responder ports
`timescale 1ns/10ps
`default_nettype none
module sfsr_chk
  import sfsr_pkg::*;
(
  input wire logic [0:0]          clock_in,
  input wire logic                resetn_in,
  input wire logic                ce_in,
  input wire logic [SRC_W-1:0]    int_event_in,
  input wire logic [SRC_W-1:0]    wake_event_in,
  input wire logic [SRC_W-1:0]    reset_event_in,
  input wire logic [STATUS_W-1:0] status_word_out,
  input wire logic                frame_done_out,
  input wire logic [CMD_W-1:0]    frame_cmd_out,
  input wire logic [ADDR_W-1:0]   frame_addr_out
);
  logic [STATUS_W-1:0] sw;
  assign sw = status_word_out;
  default clocking @(posedge clock_in); endclocking
  default disable iff (!resetn_in);
  a_reg_group: assert property (sw[8] == (sw[0] | sw[1]))
    else $error("regulator group bit wrong");
  a_can_group: assert property (sw[12] == (sw[6] | sw[7]))
    else $error("can group bit wrong");
  a_lin_group: assert property (sw[11] == (sw[4] | sw[5]))
    else $error("lin group bit wrong");
  a_int_pend: assert property ((ce_in && |int_event_in) ##1 ce_in |-> ##1 sw[15])
    else $error("interrupt summary missing");
  a_wake_pend: assert property ((ce_in && |wake_event_in) ##1 ce_in |-> ##1 sw[14])
    else $error("wake summary missing");
  a_rst_pend: assert property ((ce_in && |reset_event_in) ##1 ce_in |-> ##1 sw[13])
    else $error("reset summary missing");
  a_done_pulse: assert property (frame_done_out && ce_in |=> !frame_done_out)
    else $error("frame done longer than one cycle");
  a_int_clear: assert property (ce_in && frame_done_out && frame_cmd_out == CMD_READ_A
    && frame_addr_out == ADDR_INT_FLAGS && $past(int_event_in) == '0 |=> !sw[15])
    else $error("interrupt summary not cleared");
  a_wake_clear: assert property (ce_in && frame_done_out && frame_cmd_out == CMD_READ_A
    && frame_addr_out == ADDR_WU_FLAGS && $past(wake_event_in) == '0 |=> !sw[14])
    else $error("wake summary not cleared");
  a_rst_clear: assert property (ce_in && frame_done_out && frame_cmd_out == CMD_READ_B
    && frame_addr_out == ADDR_RST_FLAGS && $past(reset_event_in) == '0 |=> !sw[13])
    else $error("reset summary not cleared");
endmodule : sfsr_chk
bind sfsr_top sfsr_chk i_sfsr_chk (.clock_in, .resetn_in, .ce_in, .int_event_in, .wake_event_in,
  .reset_event_in, .status_word_out, .frame_done_out, .frame_cmd_out, .frame_addr_out);
`default_nettype wire

//--- verification/sfsr_host.sv
// spi master model standing in for the host controller
`timescale 1ns/10ps
`default_nettype none
module sfsr_host (
  input  wire logic clock_in,
  input  wire logic miso_in,
  input  wire logic miso_oe_n_in,
  output var logic  sclk_out,
  output var logic  cs_n_out,
  output var logic  mosi_out
);
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    mosi_out = 1'b0;
  end
  task automatic gap(input int n);
    repeat (n) @(negedge clock_in);
  endtask : gap
  // 8 clocks a half period: sclk stands still outside frames
  task automatic xfer(input logic [15:0] tx, output logic [15:0] rx);
    cs_n_out = 1'b0;
    gap(8);
    for (int i = 15; i >= 0; i--) begin
      mosi_out = tx[i];
      // taken just before the rise; an undriven line reads unknown
      rx[i] = miso_oe_n_in ? 1'bx : miso_in;
      sclk_out = 1'b1;
      gap(8);
      sclk_out = 1'b0;
      gap(8);
    end
    cs_n_out = 1'b1;
    mosi_out = ~mosi_out;
    gap(12);
  endtask : xfer
endmodule : sfsr_host
`default_nettype wire

//--- verification/sfsr_top_tb.sv
// self-checking bench for the spi status responder
`timescale 1ns/10ps
`default_nettype none
module sfsr_top_tb
  import sfsr_pkg::*;
;
  logic                clk, rst_n, sclk, cs_n, mosi, miso, oe_n, done, ce;
  logic [SRC_W-1:0]    ev_int, ev_wake, ev_rst;
  logic [STATUS_W-1:0] status, rx;
  logic [CMD_W-1:0]    cmd;
  logic [ADDR_W-1:0]   addr;
  int                  error_cnt = 0;
  int                  checks_done = 0;
  sfsr_top i_sfsr_top (.clock_in(clk), .resetn_in(rst_n), .ce_in(ce), .sclk_in(sclk),
    .cs_n_in(cs_n), .mosi_in(mosi), .miso_out(miso), .miso_oe_n_out(oe_n), .int_event_in(ev_int),
    .wake_event_in(ev_wake), .reset_event_in(ev_rst), .status_word_out(status),
    .frame_done_out(done), .frame_cmd_out(cmd), .frame_addr_out(addr));
  sfsr_host i_sfsr_host (.clock_in(clk), .miso_in(miso), .miso_oe_n_in(oe_n), .sclk_out(sclk),
    .cs_n_out(cs_n), .mosi_out(mosi));
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic end_sim;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_sim
  task automatic pulse(input logic [3*SRC_W-1:0] v);
    {ev_rst, ev_wake, ev_int} = v;
    @(negedge clk);
    {ev_rst, ev_wake, ev_int} = '0;
    repeat (3) @(negedge clk);
  endtask : pulse
  task automatic frame(input logic [15:0] tx, input logic [15:0] exp_rx, input logic [15:0] exp_st);
    i_sfsr_host.xfer(tx, rx);
    chk("miso word", exp_rx, rx);
    chk("frame fields", {9'h000, tx[15:9]}, {9'h000, cmd, addr});
    chk("status after frame", exp_st, status);
  endtask : frame
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // a hang ends the run as a failure
  initial begin
    #100us;
    error_cnt++;
    end_sim();
  end
  initial begin
    rst_n = 1'b0;
    ce    = 1'b1;
    {ev_rst, ev_wake, ev_int} = '0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
    chk("status reset", STATUS_RST, status);
    frame(16'h0000, 16'h0000, 16'h0000);
    // an event while the clock enable is low is not taken
    ce = 1'b0;
    pulse(27'h1 << SRC_SAFE);
    ce = 1'b1;
    chk("status while frozen", 16'h0000, status);
    pulse(27'h1 << SRC_CANLOC);
    chk("int pending", 16'h9040, status);
    frame(16'h4000, 16'h9040, 16'h9040);
    pulse(27'h1 << (SRC_W + SRC_VREG1));
    chk("wake pending", 16'hD142, status);
    frame(16'hC000, 16'hD100, 16'hD142);
    pulse(27'h1 << (2 * SRC_W + SRC_LIN_CHANNEL_TWO_SOURCE));
    chk("reset pending", 16'hF962, status);
    frame(16'h3800, 16'hF900, 16'h6922);
    frame(16'h7A00, 16'h6922, 16'h6922);
    frame(16'h3A00, 16'h6900, 16'h2820);
    frame(16'hBC00, 16'h2800, 16'h2820);
    frame(16'hFC00, 16'h2800, 16'h0000);
    pulse(27'h1 << (2 * SRC_W + SRC_IO0));
    chk("io reset pending", 16'h2404, status);
    // a reset in mid-run drops every pending flag
    rst_n = 1'b0;
    repeat (3) @(negedge clk);
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
    chk("status after reset", STATUS_RST, status);
    end_sim();
  end
endmodule : sfsr_top_tb
`default_nettype wire
